// >>> hdl/cafr_pkg.sv
package cafr_pkg;
  // Register word addresses on the plain port
  localparam logic [3:0] ADDR_GROUP_TWO = 4'h0;
  localparam logic [3:0] ADDR_GROUP_THREE = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  // Field positions inside one filter byte lane
  localparam int LANE_W = 8;
  localparam int ON_POS = 7;
  localparam int MASK_HI = 6;
  localparam int MASK_LO = 5;
  localparam int DEST_HI = 4;
  localparam int DEST_LO = 0;
  // Filters 8..15 as lanes 0..7; 8, 9 held in group two, 12..15 in three, 10 and 11 not held
  localparam int NUM_FILT = 8;
  localparam int FIRST_FILT = 8;
  localparam int GROUP_THREE_LANE = 4;
  localparam logic [7:0] LANE_RESET = 8'h00;
  localparam logic [31:0] GROUP_TWO_USED = 32'h0000ffff;

  // One filter's routing outputs
  typedef struct packed {
    logic on;
    logic [1:0] maskChoice;
    logic [4:0] destination;
  } cafr_route_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cafr_req_t;
endpackage

// >>> hdl/cafr_lane.sv
`timescale 1ns/1ns
module cafr_lane (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic wrEn, // Write to this lane
  input wire logic [7:0] wdata, // Lane write data
  output cafr_pkg::cafr_route_t route // Lane contents
);
  import cafr_pkg::*;

  // One filter byte; routing fields locked while the filter is on
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      route <= cafr_route_t'(LANE_RESET);
    end else if (wrEn) begin
      route.on <= wdata[ON_POS];
      if (!route.on) begin
        route.maskChoice <= wdata[MASK_HI:MASK_LO];
        route.destination <= wdata[DEST_HI:DEST_LO];
      end
    end
  end
endmodule

// >>> hdl/cafr_filter_routing.sv
`timescale 1ns/1ns
// Function
// - Per-filter enable bit turns acceptance on
// - Two-bit field picks one of four masks
// - Five-bit field picks destination FIFO buffer
// - Group two holds filters 8 and 9
// - Group three lanes hold filters 12 to 15
// - Group three readable, writable, resets to zero
// - Routing fields locked while filter enabled
module cafr_filter_routing (
  input wire logic sys_clk, // System clock, 20 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [3:0] regAddr, // Register word address
  input wire logic [31:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [31:0] regRdata, // Read data, cycle after strobe
  output logic [cafr_pkg::NUM_FILT-1:0] filtOn, // Filter 8..15 active
  output logic [cafr_pkg::NUM_FILT*2-1:0] filtMask, // Mask choice
  output logic [cafr_pkg::NUM_FILT*5-1:0] filtDest // FIFO index
);
  import cafr_pkg::*;

  // Byte lanes in one 32-bit register word
  localparam int LANES_PER_WORD = 32 / LANE_W;

  // Register port request and decoded strobes
  cafr_req_t req;
  logic wrGroupTwo;
  logic wrGroupThree;
  logic rdGroupTwo;
  logic rdGroupThree;
  logic rdStatus;

  // Filter lanes, their write enables and the write word lanes
  cafr_route_t route [NUM_FILT];
  logic [NUM_FILT-1:0] laneWr;
  logic [LANE_W-1:0] wordLane [LANES_PER_WORD];

  // Readback images and read data next value
  logic [31:0] groupTwo;
  logic [31:0] groupThree;
  logic [31:0] statusWord;
  logic [31:0] nxt_rdata;

  // Routing outputs next values
  logic [NUM_FILT-1:0] nxt_filtOn;
  logic [NUM_FILT*2-1:0] nxt_filtMask;
  logic [NUM_FILT*5-1:0] nxt_filtDest;

  // Byte lane k of a register word
  function automatic logic [LANE_W-1:0] laneOf(input logic [31:0] w,
                                               input int k);
    laneOf = w[k*LANE_W +: LANE_W];
  endfunction

  // Strobe high at the wanted word address
  function automatic logic hitAt(input logic strobe,
                                 input logic [3:0] a,
                                 input logic [3:0] want);
    hitAt = strobe && (a == want);
  endfunction

  // Mask choice shown to the comparison engine; zero when off
  function automatic logic [1:0] gateMask(input cafr_route_t r);
    gateMask = r.on ? r.maskChoice : 2'h0;
  endfunction

  // FIFO index shown to the comparison engine; zero when off
  function automatic logic [4:0] gateDest(input cafr_route_t r);
    gateDest = r.on ? r.destination : 5'h00;
  endfunction

  // Request carrier from the plain port
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Address decode of both strobes
  assign wrGroupTwo = hitAt(req.wr, req.addr, ADDR_GROUP_TWO);
  assign wrGroupThree = hitAt(req.wr, req.addr, ADDR_GROUP_THREE);
  assign rdGroupTwo = hitAt(req.rd, req.addr, ADDR_GROUP_TWO);
  assign rdGroupThree = hitAt(req.rd, req.addr, ADDR_GROUP_THREE);
  assign rdStatus = hitAt(req.rd, req.addr, ADDR_STATUS);

  // Lane write enables: lanes 0, 1 in group two, 4 to 7 in three
  always_comb begin
    laneWr = '0;
    laneWr[0] = wrGroupTwo;
    laneWr[1] = wrGroupTwo;
    laneWr[NUM_FILT-1:GROUP_THREE_LANE] = {4{wrGroupThree}};
  end

  // Byte lanes of the write word, shared by both groups
  for (genvar j = 0; j < LANES_PER_WORD; j++) begin : g_word
    assign wordLane[j] = laneOf(req.wdata, j);
  end

  // Filter 8: group two bits 7:0
  cafr_lane u_filt8 (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(laneWr[0]),
    .wdata(wordLane[0]),
    .route(route[0])
  );

  // Filter 9: group two bits 15:8
  cafr_lane u_filt9 (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(laneWr[1]),
    .wdata(wordLane[1]),
    .route(route[1])
  );

  // Filter 12: group three bits 7:0
  cafr_lane u_filt12 (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(laneWr[4]),
    .wdata(wordLane[0]),
    .route(route[4])
  );

  // Filter 13: group three bits 15:8
  cafr_lane u_filt13 (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(laneWr[5]),
    .wdata(wordLane[1]),
    .route(route[5])
  );

  // Filter 14: group three bits 23:16
  cafr_lane u_filt14 (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(laneWr[6]),
    .wdata(wordLane[2]),
    .route(route[6])
  );

  // Filter 15: group three bits 31:24
  cafr_lane u_filt15 (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(laneWr[7]),
    .wdata(wordLane[3]),
    .route(route[7])
  );

  // Filters 10 and 11 are not held here; lanes stay at reset value
  assign route[2] = cafr_route_t'(LANE_RESET);
  assign route[3] = cafr_route_t'(LANE_RESET);

  // Readback images; group two upper half reads zero
  assign groupTwo = {16'h0000, route[1], route[0]} & GROUP_TWO_USED;
  assign groupThree = {route[7], route[6], route[5], route[4]};
  assign statusWord = {24'h000000, filtOn};

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (rdGroupTwo) begin
      nxt_rdata = groupTwo;
    end else if (rdGroupThree) begin
      nxt_rdata = groupThree;
    end else if (rdStatus) begin
      nxt_rdata = statusWord;
    end
  end

  // Read data register; zero outside the cycle after a read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdata <= 32'h00000000;
    end else begin
      regRdata <= nxt_rdata;
    end
  end

  // Enable of every filter
  always_comb begin
    nxt_filtOn = '0;
    for (int k = 0; k < NUM_FILT; k++) begin
      nxt_filtOn[k] = route[k].on;
    end
  end

  // Mask choice per filter, hidden while the filter is off
  always_comb begin
    nxt_filtMask = '0;
    for (int k = 0; k < NUM_FILT; k++) begin
      nxt_filtMask[k*2 +: 2] = gateMask(route[k]);
    end
  end

  // FIFO index per filter, hidden while the filter is off
  always_comb begin
    nxt_filtDest = '0;
    for (int k = 0; k < NUM_FILT; k++) begin
      nxt_filtDest[k*5 +: 5] = gateDest(route[k]);
    end
  end

  // Enable outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filtOn <= '0;
    end else begin
      filtOn <= nxt_filtOn;
    end
  end

  // Mask choice outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filtMask <= '0;
    end else begin
      filtMask <= nxt_filtMask;
    end
  end

  // FIFO index outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filtDest <= '0;
    end else begin
      filtDest <= nxt_filtDest;
    end
  end
endmodule

// >>> dv/cafr_filter_routing_props.sv
`timescale 1ns/1ns
module cafr_filter_routing_props (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [3:0] regAddr, // Address
  input wire logic [31:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  input wire logic [31:0] regRdata, // Read data
  input wire logic [7:0] filtOn, // Enables
  input wire logic [15:0] filtMask, // Masks
  input wire logic [39:0] filtDest // Destinations
);
  import cafr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Write steps
  sequence wr3; regWr && regAddr == ADDR_GROUP_THREE; endsequence
  sequence wr2; regWr && regAddr == ADDR_GROUP_TWO; endsequence
  // Group three write turning filter 15 on while its fields are open
  sequence fresh3;
    wr3 and (regWdata[31] && !filtOn[7] && !$past(regWr));
  endsequence
  a_on_three: assert property (
    wr3 |-> ##2 filtOn[4] == $past(regWdata[7], 2)) else $error("enable");
  a_on_two: assert property (
    wr2 |-> ##2 filtOn[1] == $past(regWdata[15], 2)) else $error("enable");
  a_mask_route: assert property (fresh3 |-> ##2
    filtMask[15:14] == $past(regWdata[30:29], 2)) else $error("mask");
  a_dest_route: assert property (fresh3 |-> ##2
    filtDest[39:35] == $past(regWdata[28:24], 2)) else $error("dest");
  a_field_lock: assert property (
    filtOn[7] && $past(filtOn[7]) |-> $stable(filtDest[39:35]))
    else $error("lock");
  a_off_silent: assert property (
    !filtOn[0] |-> filtMask[1:0] == 2'h0 && filtDest[4:0] == 5'h0)
    else $error("off");
  a_upper_zero: assert property (
    regRd && regAddr == 4'h0 |=> regRdata[31:16] == 16'h0) else $error("upper");
  a_lane_place: assert property (
    filtOn[3:2] == 2'h0) else $error("lanes");
endmodule
bind cafr_filter_routing cafr_filter_routing_props u_props (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .filtOn(filtOn),
  .filtMask(filtMask), .filtDest(filtDest));

// >>> dv/cafr_filter_routing_tb_top.sv
`timescale 1ns/1ns
module cafr_filter_routing_tb_top;
  import cafr_pkg::*;
  logic sys_clk = 0, rst = 1, regWr = 0, regRd = 0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [7:0] filtOn;
  logic [15:0] filtMask;
  logic [39:0] filtDest;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  // Clock and hang limit
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cycles == 300) begin
    fail_count++;
    tally_and_finish();
  end
  cafr_filter_routing DUT (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .filtOn(filtOn), .filtMask(filtMask), .filtDest(filtDest));
  // Compare and bus tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk) {regWr, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge sys_clk) regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk) {regRd, regAddr} <= {1'b1, a};
    @(posedge sys_clk) regRd <= 1'b0;
    #1 chk({32'h0, regRdata}, {32'h0, e});
  endtask
  task automatic outs(input logic [63:0] e);
    @(posedge sys_clk);
    #1 chk({filtOn, filtMask, filtDest}, e);
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Register and routing sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h1, 32'h0);
    wr(4'h1, 32'hffc0b581);
    outs(64'hf0e400f82a100000);
    rd(4'h1, 32'hffc0b581);
    wr(4'h1, 32'h80808080);
    rd(4'h1, 32'hffc0b581);
    wr(4'h1, 32'h0);
    outs(64'h0);
    rd(4'h1, 32'h7f403501);
    wr(4'h1, 32'hc241009f);
    outs(64'h9080001001f00000);
    rd(4'h1, 32'hc241009f);
    // Reset again in mid-run; everything returns to zero
    @(posedge sys_clk) rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    outs(64'h0);
    rd(4'h1, 32'h0);
    wr(4'h0, 32'hffff60a3);
    outs(64'h0100010000000003);
    rd(4'h0, 32'h000060a3);
    rd(4'h2, 32'h00000001);
    wr(4'hf, 32'hffffffff);
    rd(4'hf, 32'h0);
    tally_and_finish();
  end
endmodule
